//--- pkg/dlp_map.svh
`ifndef DLP_MAP_SVH
`define DLP_MAP_SVH
// Function
// (RULE1) eight banks, three bank bits, fourteen row bits
// (RULE2) lowest column bit never sent, taken as zero
// (RULE3) unused row and column positions are ignored
// (RULE4) activate opens row and bank for later access
// (RULE5) read or write captures bank and start column
// (RULE6) 8n core word moves as eight half-clock beats
// (RULE7) bursts run programmed length in programmed order; length is fixed at eight beats here
// (RULE8) controller initialises device before normal commands
// (RULE9) address sampled both edges, select and enable rising
// (RULE10) masked write bytes are never stored
// (RULE11) column commands only to bank with open row

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define DLP_BANKS      8
`define DLP_BANK_W     3
`define DLP_ROW_W      14
`define DLP_COL_W      10
`define DLP_CA_W       10
`define DLP_DQ_W       16
`define DLP_MASK_W     2
`define DLP_BURST_W    128
`define DLP_PAIRS      4
`define DLP_MEM_AW     10

// ----------------------------------------------------------------
// command codes and field positions on the rising and falling halves of the bus
// ----------------------------------------------------------------
`define DLP_CMD_NOP    3'h0
`define DLP_CMD_ACT    3'h1
`define DLP_CMD_RD     3'h2
`define DLP_CMD_WR     3'h3
`define DLP_CMD_MRW    3'h4
`define DLP_CMD_PRE    3'h5
`define DLP_CMD_LSB    0
`define DLP_BANK_LSB   3
`define DLP_HI_LSB     6
`define DLP_HI_W       4
`define DLP_CLO_W      5
`define DLP_MRW_ORDER  0
`define DLP_MRW_INIT   1

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define DLP_RST_OE_N   1'b1
`define DLP_RST_CS_N   1'b1
`define DLP_CLK_MHZ    25
`define DLP_INIT_NS    200000
`define DLP_INIT_CYC   ((`DLP_INIT_NS * `DLP_CLK_MHZ + 999) / 1000)
`endif

//--- pkg/dlp_pkg.sv
`include "dlp_map.svh"
package dlp_pkg;
  // ----------------------------------------------------------------
  // device end states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_IDLE  = 3'b001,
    DEV_READ  = 3'b010,
    DEV_WRITE = 3'b100
  } dlp_dev_st_t;

  // ----------------------------------------------------------------
  // controller end states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    CT_INIT = 8'b00000001,
    CT_MRW  = 8'b00000010,
    CT_IDLE = 8'b00000100,
    CT_PRE  = 8'b00001000,
    CT_ACT  = 8'b00010000,
    CT_COL  = 8'b00100000,
    CT_WDAT = 8'b01000000,
    CT_RDAT = 8'b10000000
  } dlp_ctl_st_t;

  typedef struct packed {
    dlp_dev_st_t                               st;
    logic                                      initDone;
    logic                                      ilv;
    logic [`DLP_BANKS-1:0]                     open;
    logic [`DLP_BANKS-1:0][`DLP_ROW_W-1:0]     rows;
    logic [`DLP_BANK_W-1:0]                    bank;
    logic [`DLP_ROW_W-1:0]                     row;
    logic [`DLP_COL_W-1:0]                     col;
    logic [1:0]                                pair;
    logic [`DLP_DQ_W-1:0]                      dqR;
    logic [`DLP_DQ_W-1:0]                      dqF;
    logic                                      dqs;
    logic                                      drvN;
    logic                                      err;
  } dlp_dev_t;

  typedef struct packed {
    dlp_ctl_st_t                               st;
    logic [15:0]                               cnt;
    logic                                      initDone;
    logic [`DLP_BANKS-1:0]                     open;
    logic [`DLP_BANKS-1:0][`DLP_ROW_W-1:0]     rows;
    logic                                      wr;
    logic [`DLP_BANK_W-1:0]                    bank;
    logic [`DLP_ROW_W-1:0]                     row;
    logic [`DLP_COL_W-1:0]                     col;
    logic [`DLP_BURST_W-1:0]                   wdata;
    logic [15:0]                               mask;
    logic [1:0]                                pair;
    logic [`DLP_BURST_W-1:0]                   rdata;
    logic                                      rspValid;
    logic                                      cke;
    logic                                      csN;
    logic [`DLP_CA_W-1:0]                      caR;
    logic [`DLP_CA_W-1:0]                      caF;
    logic [`DLP_DQ_W-1:0]                      dqR;
    logic [`DLP_DQ_W-1:0]                      dqF;
    logic [`DLP_MASK_W-1:0]                    dmR;
    logic [`DLP_MASK_W-1:0]                    dmF;
    logic                                      dqs;
    logic                                      drvN;
  } dlp_ctl_t;

  // beat offset inside the aligned group of eight columns
  function automatic logic [2:0] dlp_beat_col(input logic [2:0] start,
                                              input logic [2:0] beat,
                                              input logic       ilv);
    return ilv ? (start ^ beat) : 3'(start + beat);
  endfunction

  // storage is folded: only low row and column bits reach the array
  function automatic logic [`DLP_MEM_AW-1:0] dlp_mem_idx(
      input logic [`DLP_BANK_W-1:0] bank,
      input logic [`DLP_ROW_W-1:0]  row,
      input logic [`DLP_COL_W-1:0]  col);
    return {bank, row[1:0], col[4:0]};
  endfunction
endpackage

//--- pkg/dlp_link_if.sv
`include "dlp_map.svh"
interface dlp_link_if;
  logic                   cke;
  logic                   csN;
  logic [`DLP_CA_W-1:0]   caRise;
  logic [`DLP_CA_W-1:0]   caFall;
  logic [`DLP_MASK_W-1:0] maskRise;
  logic [`DLP_MASK_W-1:0] maskFall;
  logic [`DLP_DQ_W-1:0]   ctlDqRise;
  logic [`DLP_DQ_W-1:0]   ctlDqFall;
  logic                   ctlDqs;
  logic                   ctlOeN;
  logic [`DLP_DQ_W-1:0]   devDqRise;
  logic [`DLP_DQ_W-1:0]   devDqFall;
  logic                   devDqs;
  logic                   devOeN;
  logic [`DLP_DQ_W-1:0]   dqRise;
  logic [`DLP_DQ_W-1:0]   dqFall;
  logic                   dqs;

  // shared data wires: whichever end has its enable low owns them; the controller wins if both are low
  assign dqRise = !ctlOeN ? ctlDqRise : (!devOeN ? devDqRise : '0);
  assign dqFall = !ctlOeN ? ctlDqFall : (!devOeN ? devDqFall : '0);
  assign dqs    = !ctlOeN ? ctlDqs : (!devOeN ? devDqs : 1'b0);

  modport ctl (output cke, csN, caRise, caFall, maskRise, maskFall,
               output ctlDqRise, ctlDqFall, ctlDqs, ctlOeN,
               input  dqRise, dqFall, dqs);
  modport dev (input  cke, csN, caRise, caFall, maskRise, maskFall,
               output devDqRise, devDqFall, devDqs, devOeN,
               input  dqRise, dqFall, dqs);
endinterface

//--- rtl/dlp_device.sv
`include "dlp_map.svh"
module dlp_device (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  dlp_link_if.dev                    link,
  output logic                       initDone,
  output logic [`DLP_BANKS-1:0]      openBanks,
  output logic                       burstBusy,
  output logic                       cmdErr
);
  import dlp_pkg::*;

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  localparam dlp_dev_t DEV_RST = '{st: DEV_IDLE, drvN: `DLP_RST_OE_N,
                                   default: '0};

  dlp_dev_t                   q;
  dlp_dev_t                   d;

  // folded array, kept over reset
  logic [`DLP_DQ_W-1:0]       mem [2**`DLP_MEM_AW];

  // command fields, valid while select is low
  logic                       cmdValid;
  logic [2:0]                 cmdCode;
  logic [`DLP_BANK_W-1:0]     cmdBank;
  logic [`DLP_ROW_W-1:0]      actRow;
  logic [`DLP_COL_W-1:0]      startCol;

  // per-beat address and lanes, two beats per clock
  logic [`DLP_MEM_AW-1:0]     beatIdx [2];
  logic                       wrEn;
  logic [`DLP_DQ_W-1:0]       wrBeat [2];
  logic [`DLP_MASK_W-1:0]     wrMask [2];

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // select and enable are single samples per clock, the address uses both halves
  assign cmdValid = link.cke && !link.csN;                         // [RULE9]
  assign cmdCode  = link.caRise[`DLP_CMD_LSB +: 3];
  assign cmdBank  = link.caRise[`DLP_BANK_LSB +: `DLP_BANK_W];     // [RULE1]

  // row takes the high rising bits and all ten falling bits
  assign actRow   = {link.caRise[`DLP_HI_LSB +: `DLP_HI_W],
                     link.caFall};                                 // [RULE1]

  // falling bits above the carried column bits are dropped here
  assign startCol = {link.caRise[`DLP_HI_LSB +: `DLP_HI_W],
                     link.caFall[`DLP_CLO_W-1:0], 1'b0};           // [RULE2] [RULE3]

  // ----------------------------------------------------------------
  // burst addressing
  // ----------------------------------------------------------------
  // both beats of a clock share one pair count; the order bit picks wrap
  generate
    for (genvar b = 0; b < 2; b++) begin : g_beat
      assign beatIdx[b] = dlp_mem_idx(q.bank, q.row,
                            {q.col[`DLP_COL_W-1:3],
                             dlp_beat_col(q.col[2:0], {q.pair, 1'(b)}, q.ilv)}); // [RULE7]
    end
  endgenerate

  assign wrBeat[0] = link.dqRise;
  assign wrBeat[1] = link.dqFall;

  assign wrMask[0] = link.maskRise;
  assign wrMask[1] = link.maskFall;
  // strobe qualifies write data; without it the beat pair is not taken
  assign wrEn      = (q.st == DEV_WRITE) && link.dqs;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // refused commands only pulse the error flag
  always_comb begin
    d      = q;
    d.err  = 1'b0;
    d.dqs  = 1'b0;
    d.drvN = `DLP_RST_OE_N;
    d.dqR  = '0;
    d.dqF  = '0;
    case (q.st)
      DEV_IDLE: begin
        if (cmdValid) begin
          case (cmdCode)
            `DLP_CMD_NOP: begin
            end

            `DLP_CMD_MRW: begin
              // order bit holds until the next mode write
              d.ilv = link.caFall[`DLP_MRW_ORDER];                 // [RULE7]
              if (link.caFall[`DLP_MRW_INIT]) begin
                d.initDone = 1'b1;
              end
            end

            `DLP_CMD_ACT: begin
              // opening an already open bank is a sequencing fault
              if (!q.initDone || q.open[cmdBank]) begin
                d.err = 1'b1;
              end else begin
                d.open[cmdBank] = 1'b1;                            // [RULE4]
                d.rows[cmdBank] = actRow;                          // [RULE4]
              end
            end

            `DLP_CMD_PRE: begin
              // closing a closed bank is harmless
              d.open[cmdBank] = 1'b0;
            end

            `DLP_CMD_RD, `DLP_CMD_WR: begin
              if (!q.initDone || !q.open[cmdBank]) begin
                d.err = 1'b1;
              end else begin
                d.bank = cmdBank;                                  // [RULE5]
                d.row  = q.rows[cmdBank];                          // [RULE4]
                d.col  = startCol;                                 // [RULE5]
                d.pair = 2'h0;
                d.st   = (cmdCode == `DLP_CMD_RD) ? DEV_READ : DEV_WRITE;
              end
            end

            default: begin
              d.err = 1'b1;
            end
          endcase
        end
      end

      DEV_READ: begin
        // bursts cannot be cut short, so any command other than a no-op is refused
        if (cmdValid && cmdCode != `DLP_CMD_NOP) begin
          d.err = 1'b1;
        end

        // one core word leaves as two half-clock beats per clock
        d.dqR  = mem[beatIdx[0]];                                  // [RULE6]
        d.dqF  = mem[beatIdx[1]];                                  // [RULE6]
        d.dqs  = 1'b1;
        d.drvN = 1'b0;

        d.pair = 2'(q.pair + 2'h1);                                // [RULE7]
        if (q.pair == 2'h3) begin
          d.st = DEV_IDLE;
        end
      end

      DEV_WRITE: begin
        // refused as in a read burst
        if (cmdValid && cmdCode != `DLP_CMD_NOP) begin
          d.err = 1'b1;
        end

        if (wrEn) begin
          d.pair = 2'(q.pair + 2'h1);                              // [RULE7]
          if (q.pair == 2'h3) begin
            d.st = DEV_IDLE;
          end
        end
      end

      default: begin
        d = DEV_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // whole state in one register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // storage write port
  // ----------------------------------------------------------------
  // contents are kept over reset, as in a real array; byte lanes stay
  // untouched where the mask was high with that beat
  always_ff @(posedge clk_sys) begin
    for (int b = 0; b < 2; b++) begin
      for (int y = 0; y < `DLP_MASK_W; y++) begin
        if (wrEn && !wrMask[b][y]) begin                           // [RULE10]
          mem[beatIdx[b]][y*8 +: 8] <= wrBeat[b][y*8 +: 8];        // [RULE6]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.devDqRise = q.dqR;
  assign link.devDqFall = q.dqF;
  assign link.devDqs    = q.dqs;
  assign link.devOeN    = q.drvN;

  // status for the user side
  assign initDone       = q.initDone;
  assign openBanks      = q.open;
  assign burstBusy      = (q.st != DEV_IDLE);
  assign cmdErr         = q.err;
endmodule

//--- rtl/dlp_controller.sv
`include "dlp_map.svh"
module dlp_controller #(
  parameter int unsigned INIT_CYC = `DLP_INIT_CYC
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  dlp_link_if.ctl                       link,
  input  wire logic                     cfgInterleave,
  input  wire logic                     reqValid,
  input  wire logic                     reqWrite,
  input  wire logic [`DLP_BANK_W-1:0]   reqBank,
  input  wire logic [`DLP_ROW_W-1:0]    reqRow,
  input  wire logic [`DLP_COL_W-1:0]    reqCol,
  input  wire logic [`DLP_BURST_W-1:0]  reqWdata,
  input  wire logic [15:0]              reqMask,
  output logic                          reqReady,
  output logic                          rspValid,
  output logic [`DLP_BURST_W-1:0]       rspData,
  output logic                          initDone
);
  import dlp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam dlp_ctl_t CTL_RST = '{st: CT_INIT, csN: `DLP_RST_CS_N,
                                   drvN: `DLP_RST_OE_N, default: '0};

  dlp_ctl_t q;
  dlp_ctl_t d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.csN      = `DLP_RST_CS_N;
    d.caR      = '0;
    d.caF      = '0;
    d.dqR      = '0;
    d.dqF      = '0;
    d.dmR      = '0;
    d.dmF      = '0;
    d.dqs      = 1'b0;
    d.drvN     = `DLP_RST_OE_N;
    d.rspValid = 1'b0;
    case (q.st)
      CT_INIT: begin
        // only no-ops go out until the idle time has passed
        d.cke = 1'b1;
        d.cnt = 16'(q.cnt + 16'h0001);
        if (q.cnt == 16'(INIT_CYC - 1)) begin                      // [RULE8]
          d.st = CT_MRW;
        end
      end
      CT_MRW: begin
        d.csN = 1'b0;
        d.caR[`DLP_CMD_LSB +: 3]  = `DLP_CMD_MRW;
        d.caF[`DLP_MRW_ORDER]     = cfgInterleave;                 // [RULE7]
        d.caF[`DLP_MRW_INIT]      = 1'b1;                          // [RULE8]
        d.initDone                = 1'b1;
        d.st                      = CT_IDLE;
      end
      CT_IDLE: begin
        if (reqValid) begin
          d.wr    = reqWrite;
          d.bank  = reqBank;
          d.row   = reqRow;
          d.col   = reqCol;
          d.wdata = reqWdata;
          d.mask  = reqMask;
          // a hit goes straight to the column command
          if (q.open[reqBank] && q.rows[reqBank] == reqRow) begin  // [RULE11]
            d.st = CT_COL;
          end else if (q.open[reqBank]) begin
            d.st = CT_PRE;
          end else begin
            d.st = CT_ACT;
          end
        end
      end
      CT_PRE: begin
        d.csN = 1'b0;
        d.caR[`DLP_CMD_LSB +: 3]           = `DLP_CMD_PRE;
        d.caR[`DLP_BANK_LSB +: `DLP_BANK_W] = q.bank;
        d.open[q.bank]                     = 1'b0;
        d.st                               = CT_ACT;
      end
      CT_ACT: begin
        d.csN = 1'b0;
        d.caR = {q.row[`DLP_ROW_W-1 -: `DLP_HI_W], q.bank, `DLP_CMD_ACT}; // [RULE4] [RULE1]
        d.caF = q.row[`DLP_CA_W-1:0];
        d.open[q.bank] = 1'b1;
        d.rows[q.bank] = q.row;
        d.st           = CT_COL;
      end
      CT_COL: begin
        d.csN = 1'b0;
        d.caR = {q.col[`DLP_COL_W-1 -: `DLP_HI_W], q.bank,
                 (q.wr ? `DLP_CMD_WR : `DLP_CMD_RD)};
        d.caF[`DLP_CLO_W-1:0] = q.col[`DLP_CLO_W:1];               // [RULE2]
        d.pair = 2'h0;
        d.st   = q.wr ? CT_WDAT : CT_RDAT;
      end
      CT_WDAT: begin
        d.dqR  = q.wdata[{q.pair, 5'h00} +: `DLP_DQ_W];
        d.dqF  = q.wdata[{q.pair, 5'h10} +: `DLP_DQ_W];
        d.dmR  = q.mask[{q.pair, 2'h0} +: `DLP_MASK_W];            // [RULE10]
        d.dmF  = q.mask[{q.pair, 2'h2} +: `DLP_MASK_W];
        d.dqs  = 1'b1;
        d.drvN = 1'b0;
        d.pair = 2'(q.pair + 2'h1);
        if (q.pair == 2'h3) begin
          d.st = CT_IDLE;
        end
      end
      CT_RDAT: begin
        // waits for the device strobe; no timeout, the far end always answers
        if (link.dqs) begin
          d.rdata[{q.pair, 5'h00} +: 2*`DLP_DQ_W] = {link.dqFall, link.dqRise};
          d.pair = 2'(q.pair + 2'h1);
          if (q.pair == 2'h3) begin
            d.rspValid = 1'b1;
            d.st       = CT_IDLE;
          end
        end
      end
      default: begin
        d = CTL_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= CTL_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.cke       = q.cke;
  assign link.csN       = q.csN;
  assign link.caRise    = q.caR;
  assign link.caFall    = q.caF;
  assign link.maskRise  = q.dmR;
  assign link.maskFall  = q.dmF;
  assign link.ctlDqRise = q.dqR;
  assign link.ctlDqFall = q.dqF;
  assign link.ctlDqs    = q.dqs;
  assign link.ctlOeN    = q.drvN;
  assign reqReady       = (q.st == CT_IDLE);
  assign rspValid       = q.rspValid;
  assign rspData        = q.rdata;
  assign initDone       = q.initDone;
endmodule

//--- dv/dlp_link_monitor.sv
`include "dlp_map.svh"
module dlp_link_monitor (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic                   cke,
  input wire logic                   csN,
  input wire logic [`DLP_CA_W-1:0]   caRise,
  input wire logic [`DLP_CA_W-1:0]   caFall,
  input wire logic [`DLP_MASK_W-1:0] maskRise,
  input wire logic [`DLP_MASK_W-1:0] maskFall,
  input wire logic                   ctlOeN,
  input wire logic                   devOeN,
  input wire logic                   dqs
);
  timeunit 1ns;
  timeprecision 100ps;
  logic                  take;
  logic [2:0]            cmd;
  logic [`DLP_BANKS-1:0] openQ;
  logic                  initQ;
  assign take = !csN && cke;
  assign cmd  = caRise[2:0];
  // shadow of the bank table, so column commands can be judged on the wire
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      openQ <= '0;
      initQ <= 1'b0;
    end else if (take) begin
      if (cmd == `DLP_CMD_ACT) openQ[caRise[5:3]] <= 1'b1;
      if (cmd == `DLP_CMD_PRE) openQ[caRise[5:3]] <= 1'b0;
      if (cmd == `DLP_CMD_MRW && caFall[1]) initQ <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sel_with_cke_a: assert property (!csN |-> cke)
    else $error("select low without clock enable");
  rd_burst_a: assert property (take && cmd == `DLP_CMD_RD |-> ##2 (!devOeN && dqs) [*4] ##1 devOeN)
    else $error("read burst not four beat pairs");
  wr_burst_a: assert property (take && cmd == `DLP_CMD_WR |-> ##1 (!ctlOeN && dqs) [*4] ##1 ctlOeN)
    else $error("write burst not four beat pairs");
  no_clash_a: assert property (!(!ctlOeN && !devOeN))
    else $error("both ends drive data");
  init_first_a: assert property (take && cmd inside {`DLP_CMD_ACT, `DLP_CMD_RD, `DLP_CMD_WR} |-> initQ)
    else $error("access before initialisation");
  col_open_a: assert property (take && cmd inside {`DLP_CMD_RD, `DLP_CMD_WR} |-> openQ[caRise[5:3]])
    else $error("column command to closed bank");
  act_closed_a: assert property (take && cmd == `DLP_CMD_ACT |-> !openQ[caRise[5:3]])
    else $error("activate to open bank");
  mask_in_write_a: assert property (maskRise != '0 || maskFall != '0 |-> !ctlOeN && dqs)
    else $error("mask outside write data");
endmodule

//--- dv/dram_bank_row_column_access_tb.sv
`include "dlp_map.svh"
module dram_bank_row_column_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dlp_pkg::*;
  logic                    clk_sys = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    cfgIlv = 1'b0;
  logic                    reqValid = 1'b0;
  logic                    reqWrite = 1'b0;
  logic [`DLP_BANK_W-1:0]  reqBank = '0;
  logic [`DLP_ROW_W-1:0]   reqRow = '0;
  logic [`DLP_COL_W-1:0]   reqCol = '0;
  logic [`DLP_BURST_W-1:0] reqWdata = '0;
  logic [15:0]             reqMask = '0;
  logic                    reqReady, rspValid, ctlInit, devInit, fInit, devErr, fErr;
  logic [`DLP_BURST_W-1:0] rspData;
  logic [`DLP_BANKS-1:0]   openBanks, fOpen;
  int                      bad_count = 0;
  int                      total_checks = 0;
  int                      cycles = 0;
  int                      lat;
  dlp_link_if lnk();
  dlp_link_if flt();
  // ----------------------------------------------------------------
  // both ends face each other; a lone device meets the bench driver
  // ----------------------------------------------------------------
  dlp_controller #(.INIT_CYC(8)) i_dlp_controller (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(lnk.ctl), .cfgInterleave(cfgIlv), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqBank(reqBank), .reqRow(reqRow), .reqCol(reqCol), .reqWdata(reqWdata),
    .reqMask(reqMask), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .initDone(ctlInit));
  dlp_device i_dlp_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk.dev),
    .initDone(devInit), .openBanks(openBanks), .burstBusy(), .cmdErr(devErr));
  dlp_device i_dlp_device_f (.clk_sys(clk_sys), .rst_n(rst_n), .link(flt.dev),
    .initDone(fInit), .openBanks(fOpen), .burstBusy(), .cmdErr(fErr));
  dlp_link_monitor i_dlp_link_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .cke(lnk.cke),
    .csN(lnk.csN), .caRise(lnk.caRise), .caFall(lnk.caFall), .maskRise(lnk.maskRise),
    .maskFall(lnk.maskFall), .ctlOeN(lnk.ctlOeN), .devOeN(lnk.devOeN), .dqs(lnk.dqs));
  initial forever #20 clk_sys = ~clk_sys;
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic cyc(input int n = 1);
    repeat (n) begin
      @(posedge clk_sys);
      #2;
    end
  endtask
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one user request; reads wait for the response and report its latency
  task automatic req(input logic wr, input logic [2:0] b, input logic [13:0] r,
                     input logic [9:0] c, input logic [127:0] d, input logic [15:0] m);
    lat = 0;
    for (int n = 0; n < 60 && reqReady !== 1'b1; n++) cyc();
    {reqValid, reqWrite, reqBank, reqRow, reqCol, reqWdata, reqMask} = {1'b1, wr, b, r, c, d, m};
    cyc();
    reqValid = 1'b0;
    while (!wr && rspValid !== 1'b1 && lat < 60) begin
      cyc();
      lat++;
    end
  endtask
  // high byte names the burst, low byte differs per beat so masks show
  function automatic logic [127:0] pat(input logic [7:0] s);
    for (int k = 0; k < 8; k++) pat[16*k +: 16] = {s, s ^ 8'(k)};
  endfunction
  function automatic logic [127:0] order(input logic [127:0] src, input int st, input logic ilv);
    for (int i = 0; i < 8; i++) order[16*i +: 16] = src[16*(ilv ? (st ^ i) : ((st + i) % 8)) +: 16];
  endfunction
  task automatic fcmd(input logic [2:0] cmd, input logic [2:0] b, input logic expErr);
    {flt.csN, flt.caRise, flt.caFall} = {1'b0, 4'h0, b, cmd, 10'h002};
    cyc();
    flt.csN = 1'b1;
    chk("cmdErr", 128'(expErr), 128'(fErr));
    cyc();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_fault();
    flt.cke = 1'b1;
    cyc();
    fcmd(`DLP_CMD_RD, 3'h2, 1'b1);
    fcmd(`DLP_CMD_MRW, 3'h0, 1'b0);
    chk("fInit", 128'h1, 128'(fInit));
    fcmd(`DLP_CMD_RD, 3'h2, 1'b1);
    fcmd(`DLP_CMD_ACT, 3'h2, 1'b0);
    chk("fOpen", 128'h04, 128'(fOpen));
    fcmd(`DLP_CMD_ACT, 3'h2, 1'b1);
  endtask
  task automatic t_hit();
    req(1'b1, 3'h0, 14'h0, 10'h000, pat(8'hA1), 16'h0);
    chk("devInit", 128'h1, 128'(devInit));
    req(1'b0, 3'h0, 14'h0, 10'h000, '0, '0);
    chk("hit latency", 128'h7, 128'(lat));
    chk("read c0", pat(8'hA1), rspData);
    req(1'b0, 3'h0, 14'h0, 10'h003, '0, '0);
    chk("read c3", order(pat(8'hA1), 2, 1'b0), rspData);
  endtask
  task automatic t_mask();
    logic [127:0] e;
    e = pat(8'hC3);
    for (int j = 0; j < 16; j++) if (16'h8005 >> j & 1) e[8*j +: 8] = 8'(pat(8'hA1) >> 8*j);
    req(1'b1, 3'h0, 14'h0, 10'h000, pat(8'hC3), 16'h8005);
    req(1'b0, 3'h0, 14'h0, 10'h000, '0, '0);
    chk("masked", e, rspData);
  endtask
  task automatic t_banks();
    req(1'b1, 3'h5, 14'h0001, 10'h008, pat(8'h51), 16'h0);
    req(1'b1, 3'h5, 14'h0002, 10'h008, pat(8'h52), 16'h0);
    req(1'b1, 3'h7, 14'h3FFF, 10'h010, pat(8'h7F), 16'h0);
    req(1'b0, 3'h5, 14'h0001, 10'h008, '0, '0);
    chk("miss latency", 128'h9, 128'(lat));
    chk("b5 r1", pat(8'h51), rspData);
    req(1'b0, 3'h7, 14'h3FFF, 10'h010, '0, '0);
    chk("b7 top row", pat(8'h7F), rspData);
    chk("openBanks", 128'hA1, 128'(openBanks));
  endtask
  // a second reset mid-run brings the device up in interleaved order
  task automatic t_ilv();
    rst_n = 1'b0;
    cfgIlv = 1'b1;
    cyc(6);
    rst_n = 1'b1;
    req(1'b1, 3'h1, 14'h0, 10'h000, pat(8'hE4), 16'h0);
    req(1'b0, 3'h1, 14'h0, 10'h006, '0, '0);
    chk("openBanks rst", 128'h02, 128'(openBanks));
    chk("ilv c6", order(pat(8'hE4), 6, 1'b1), rspData);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {flt.cke, flt.csN, flt.caRise, flt.caFall, flt.maskRise, flt.maskFall} = {2'b01, 24'h0};
    {flt.ctlDqRise, flt.ctlDqFall, flt.ctlDqs, flt.ctlOeN} = {33'h0, 1'b1};
    cyc(6);
    rst_n = 1'b1;
    t_fault();
    t_hit();
    t_mask();
    t_banks();
    t_ilv();
    complete_run();
  end
endmodule
